//--- inc/adc_demux_params.svh
// Constants for the converter demultiplexer and reset alignment path.
`ifndef ADC_DEMUX_PARAMS_SVH
`define ADC_DEMUX_PARAMS_SVH
`define ADC_SAMPLE_BITS      8
`define ADC_DEMUX_WAYS       4
`define ADC_RST_DELAY_HALF   15
`define ADC_PHASE_RESET      2'h3
`define ADC_PHASE_LAST       2'h3
`define ADC_WORD_RESET       2'h0
`endif

//--- inc/adc_demux_pkg.sv
// Types shared by the converter demultiplexer block.
package adc_demux_pkg;
    typedef enum logic [1:0] {
        MODE_SDR,
        MODE_DDR,
        MODE_QDR
    } mode_t;
endpackage : adc_demux_pkg

//--- src/adc_demux_reset_sync.sv
// Converter output demultiplexer, forwarded clock and aligned reset path.
// How it works
// - Four ports, each updated once per four samples.
// - Reset input captured on sample clock rising edge.
// - Reset delayed by the data latency pipeline.
// - Mode inputs select single, double or quad rate.
// - Reset forces divide counter to defined phase.
// - Sample order on ports independent of clock phase.
// - Forwarded clock toggles while reset output asserted.
// - Reset output follows deassertion by 7.5 cycles.
// - First word after reset updates only port three.
// - Same reset timing in every rate mode.
// - New sample taken on each rising clock edge.
// - Port data changes on forwarded clock rising edge in single rate mode.
// - Reset input resets the demultiplexer state.
`include "adc_demux_params.svh"

module adc_demux_reset_sync #(
    parameter int SAMPLE_BITS = `ADC_SAMPLE_BITS
) (
    input  wire logic                     sys_clk_in,
    input  wire logic                     arst_n_in,
    input  wire logic [SAMPLE_BITS-1:0]   sample_data_in,
    input  wire logic                     sync_reset_in,
    input  wire logic                     mode_ddr_in,
    input  wire logic                     mode_qdr_in,
    output logic      [SAMPLE_BITS-1:0]   out_port_0_out,
    output logic      [SAMPLE_BITS-1:0]   out_port_1_out,
    output logic      [SAMPLE_BITS-1:0]   out_port_2_out,
    output logic      [SAMPLE_BITS-1:0]   out_port_3_out,
    output logic                          fwd_clock_out,
    output logic                          aligned_reset_out,
    output adc_demux_pkg::mode_t          active_mode_out
);
    import adc_demux_pkg::*;

    localparam int WAYS     = `ADC_DEMUX_WAYS;
    localparam int RST_FULL = `ADC_RST_DELAY_HALF / 2;
    localparam int RST_HALF = `ADC_RST_DELAY_HALF % 2;

    logic [RST_FULL:0]      rst_pipe_reg;
    logic [SAMPLE_BITS-1:0] data_pipe_reg [RST_FULL+1];
    logic [SAMPLE_BITS-1:0] hold_reg [WAYS-1];
    logic [SAMPLE_BITS-1:0] port_reg [WAYS];
    logic [1:0]             phase_reg;
    logic [1:0]             phase_next;
    logic [1:0]             word_reg;
    logic [1:0]             word_next;
    logic                   first_reg;
    logic                   fwd_reg;
    logic                   fwd_next;
    logic [1:0]             mode_s1_reg;
    logic [1:0]             mode_s2_reg;
    logic [1:0]             mode_s3_reg;
    mode_t                  mode_reg;
    mode_t                  mode_next;
    wire                    rst_demux  = rst_pipe_reg[RST_FULL];
    wire [SAMPLE_BITS-1:0]  demux_data = data_pipe_reg[RST_FULL];
    wire                    word_evt   = !rst_demux && (phase_reg == `ADC_PHASE_LAST);
    wire                    mode_agree = (mode_s2_reg == mode_s3_reg);

    // Reset input is registered on the rising edge and shifted along with the data.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_pipe_reg <= '0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[RST_FULL-1:0], sync_reset_in};
        end
    end

    // A fresh sample enters the data latency pipeline on every rising edge.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i <= RST_FULL; i++) begin
                data_pipe_reg[i] <= '0;
            end
        end else begin
            data_pipe_reg[0] <= sample_data_in;
            for (int i = 1; i <= RST_FULL; i++) begin
                data_pipe_reg[i] <= data_pipe_reg[i-1];
            end
        end
    end

    // The final half cycle of reset delay is taken on the falling edge.
    generate
        if (RST_HALF != 0) begin : g_half
            always_ff @(negedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    aligned_reset_out <= 1'b0;
                end else begin
                    aligned_reset_out <= rst_demux;
                end
            end
        end else begin : g_full
            assign aligned_reset_out = rst_demux;
        end
    endgenerate

    // Mode pins are static straps; a change is taken once two late stages agree.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_s1_reg <= 2'h0;
            mode_s2_reg <= 2'h0;
            mode_s3_reg <= 2'h0;
            mode_reg    <= MODE_SDR;
        end else begin
            mode_s1_reg <= {mode_qdr_in, mode_ddr_in};
            mode_s2_reg <= mode_s1_reg;
            mode_s3_reg <= mode_s2_reg;
            mode_reg    <= mode_next;
        end
    end

    // Quad select wins over double select; neither gives single rate.
    assign mode_next = !mode_agree      ? mode_reg :
                       mode_s3_reg[1]   ? MODE_QDR :
                       mode_s3_reg[0]   ? MODE_DDR : MODE_SDR;
    assign active_mode_out = mode_reg;

    // Divide counter is pinned to its reset phase while reset is held.
    assign phase_next = rst_demux ? `ADC_PHASE_RESET : phase_reg + 2'h1;
    assign word_next  = rst_demux ? `ADC_WORD_RESET :
                        word_evt  ? word_reg + 2'h1 : word_reg;

    // Forwarded clock runs free during reset, then rises with each port update in single rate, every second in double, every fourth in quad.
    assign fwd_next = rst_demux           ? !fwd_reg :
                      (mode_reg == MODE_DDR) ? word_next[0] :
                      (mode_reg == MODE_QDR) ? word_next[1] :
                      !phase_next[1];

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg <= `ADC_PHASE_RESET;
            word_reg  <= `ADC_WORD_RESET;
            first_reg <= 1'b1;
            fwd_reg   <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            word_reg  <= word_next;
            first_reg <= rst_demux || (first_reg && !word_evt);
            fwd_reg   <= fwd_next;
        end
    end
    assign fwd_clock_out = fwd_reg;

    // Earlier samples of a word wait in hold registers, oldest for port zero.
    generate
        for (genvar k = 0; k < WAYS; k++) begin : g_port
            wire [SAMPLE_BITS-1:0] load_val;
            if (k < WAYS - 1) begin : g_hold
                always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                    if (!arst_n_in) begin
                        hold_reg[k] <= '0;
                    end else if (!rst_demux && phase_reg == 2'(k)) begin
                        hold_reg[k] <= demux_data;
                    end
                end
                assign load_val = hold_reg[k];
            end else begin : g_last
                // The newest sample goes straight to the last port, it has no hold stage.
                assign load_val = demux_data;
            end
            // Port three alone loads on the first word; all four load afterwards.
            always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    port_reg[k] <= '0;
                end else if (word_evt && (k == WAYS - 1 || !first_reg)) begin
                    port_reg[k] <= load_val;
                end
            end
        end
    endgenerate

    assign out_port_0_out = port_reg[0];
    assign out_port_1_out = port_reg[1];
    assign out_port_2_out = port_reg[2];
    assign out_port_3_out = port_reg[3];

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // Capture stage seen low: reset output still high six edges on, low at the seventh.
    a_reset_out_delay: assert property (
        rst_pipe_reg[0] [*8] ##1 !rst_pipe_reg[0] |-> ##6 aligned_reset_out ##1 !aligned_reset_out)
        else $error("Reset output release is not 7.5 cycles after capture.");

    // Demux reset is the reset input eight edges earlier.
    a_reset_latency: assert property (
        ##8 1 |-> rst_demux == $past(sync_reset_in, 8) && demux_data == $past(sample_data_in, 8))
        else $error("Reset and data latencies differ.");

    // Counter stays at reset phase while reset is held.
    a_phase_held: assert property (
        rst_demux [*2] |-> phase_reg == `ADC_PHASE_RESET && word_reg == `ADC_WORD_RESET)
        else $error("Divide counter moved during reset.");

    // Forwarded clock keeps toggling while reset output is high.
    a_fwd_in_reset: assert property (
        rst_demux && aligned_reset_out |=> fwd_clock_out != $past(fwd_clock_out))
        else $error("Forwarded clock stopped during reset.");

    // First word after release moves port three only.
    a_first_word: assert property (
        $fell(rst_demux) |=> out_port_3_out == $past(demux_data) && $stable(out_port_0_out)
                             && $stable(out_port_1_out) && $stable(out_port_2_out))
        else $error("First word after reset did not update port three only.");

    // The next word carries four consecutive samples in order.
    a_full_word: assert property (
        $fell(rst_demux) |-> ##5 out_port_0_out == $past(demux_data, 4)
                             && out_port_1_out == $past(demux_data, 3)
                             && out_port_2_out == $past(demux_data, 2)
                             && out_port_3_out == $past(demux_data, 1))
        else $error("Second word after reset is out of order.");

    // Port zero changes no more than once per four cycles.
    a_port_rate: assert property (
        $changed(out_port_0_out) |=> $stable(out_port_0_out) [*3])
        else $error("Port zero updated faster than one quarter rate.");

    // In single rate the forwarded clock rises as the ports change.
    a_sdr_edge: assert property (
        mode_reg == MODE_SDR && $stable(mode_reg) && !rst_demux && !$past(rst_demux)
        && $changed(out_port_3_out) |-> $rose(fwd_clock_out))
        else $error("Port change not aligned to forwarded clock rise.");

    // Mode moves only when the late strap stages agree.
    a_mode_change: assert property (
        $changed(mode_reg) |-> $past(mode_agree))
        else $error("Mode changed on an unsettled strap.");

    c_reset_release: cover property (rst_demux [*8] ##1 !rst_demux ##[1:8] !aligned_reset_out);
    c_full_word:     cover property ($fell(rst_demux) ##5 !first_reg);
    c_ddr_mode:      cover property (mode_reg == MODE_DDR && $rose(fwd_clock_out));
    c_qdr_mode:      cover property (mode_reg == MODE_QDR && $fell(rst_demux));
endmodule : adc_demux_reset_sync

//--- verif/adc_demux_reset_sync_test.sv
// Self-checking bench for the demultiplexer, forwarded clock and aligned reset.
`include "adc_demux_params.svh"
module adc_demux_reset_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_demux_pkg::*;
    localparam int W = `ADC_SAMPLE_BITS;
    logic         sys_clk_in = 1'b0, arst_n_in = 1'b0, sync_reset_in = 1'b0;
    logic         mode_ddr_in = 1'b0, mode_qdr_in = 1'b0, fwd_clock_out, aligned_reset_out;
    logic [W-1:0] sample_data_in = '0;
    logic [W-1:0] port_out [4];
    logic [W-1:0] cap_word [4];
    logic [W-1:0] old_word [4];
    logic         cap_seen;
    mode_t        active_mode_out;
    int           err_count = 0;
    int           n_tests = 0;

    adc_demux_reset_sync dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .sample_data_in(sample_data_in), .sync_reset_in(sync_reset_in),
        .mode_ddr_in(mode_ddr_in), .mode_qdr_in(mode_qdr_in), .out_port_0_out(port_out[0]),
        .out_port_1_out(port_out[1]), .out_port_2_out(port_out[2]),
        .out_port_3_out(port_out[3]), .fwd_clock_out(fwd_clock_out),
        .aligned_reset_out(aligned_reset_out), .active_mode_out(active_mode_out));
    fpga_word_receiver #(.W(W)) far_end (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .fwd_clock_in(fwd_clock_out), .port_in(port_out), .word_out(cap_word),
        .seen_out(cap_seen));

    // Clock and a counting sample stream, one new sample per rising edge once out of reset.
    always #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        if (arst_n_in) sample_data_in <= sample_data_in + 8'h01;
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic check_word(input string what, input logic [W-1:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp, got);
        check_word(what, {7'h00, exp}, {7'h00, got});
    endtask : check_bit

    // Waits, bounded, for the next change on any port and reports the gap.
    task automatic next_word(output int gap);
        old_word = port_out;
        gap = 0;
        do begin
            @(posedge sys_clk_in);
            gap++;
            if (gap > 40) begin
                err_count++;
                $display("[FAIL] port update expected within 40 seen none");
                end_sim();
            end
        end while (port_out[0] === old_word[0] && port_out[1] === old_word[1]
                   && port_out[2] === old_word[2] && port_out[3] === old_word[3]);
    endtask : next_word

    // Free-running stream: words are consecutive samples, one word per four cycles.
    task automatic stream_order();
        int gap;
        next_word(gap);
        next_word(gap);
        for (int n = 0; n < 3; n++) begin
            next_word(gap);
            check_word("word spacing", 8'h04, gap[7:0]);
            check_word("word step", old_word[0] + 8'h04, port_out[0]);
            for (int k = 1; k < 4; k++) check_word("port order", W'(port_out[0] + k), port_out[k]);
        end
        check_bit("receiver captured", 1'b1, cap_seen);
        for (int k = 1; k < 4; k++) check_word("captured order", W'(cap_word[0] + k), cap_word[k]);
    endtask : stream_order

    // One synchronizing reset in the given mode, with delay, clocking and realignment checks.
    task automatic reset_cycle(input logic ddr, qdr, input mode_t exp_mode,
                               input logic [W-1:0] exp_rises);
        int gap;
        int rises;
        logic [W-1:0] first;
        mode_ddr_in <= ddr;
        mode_qdr_in <= qdr;
        repeat (8) @(posedge sys_clk_in);
        check_word("mode", {6'h00, exp_mode}, {6'h00, active_mode_out});
        sync_reset_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        check_bit("reset out before rise", 1'b0, aligned_reset_out);
        @(posedge sys_clk_in);
        check_bit("reset out after rise", 1'b1, aligned_reset_out);
        old_word = port_out;
        repeat (4) begin
            first = {7'h00, fwd_clock_out};
            @(posedge sys_clk_in);
            check_bit("clock toggles in reset", ~first[0], fwd_clock_out);
        end
        check_word("port held in reset", old_word[3], port_out[3]);
        sync_reset_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        check_bit("reset out before fall", 1'b1, aligned_reset_out);
        @(posedge sys_clk_in);
        check_bit("reset out after fall", 1'b0, aligned_reset_out);
        next_word(gap);
        for (int k = 0; k < 3; k++) check_word("first word old port", old_word[k], port_out[k]);
        first = port_out[3];
        next_word(gap);
        check_word("second word spacing", 8'h04, gap[7:0]);
        for (int k = 0; k < 4; k++) check_word("second word", W'(first + 1 + k), port_out[k]);
        // Forwarded clock rate per mode: rising edges seen over sixteen sample edges.
        rises = 0;
        repeat (16) begin
            first = {7'h00, fwd_clock_out};
            @(posedge sys_clk_in);
            if (fwd_clock_out && !first[0]) rises++;
        end
        check_word("clock rises in 16", exp_rises, rises[7:0]);
    endtask : reset_cycle

    initial begin
        repeat (12) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        stream_order();
        reset_cycle(1'b0, 1'b0, MODE_SDR, 8'h04);
        reset_cycle(1'b1, 1'b0, MODE_DDR, 8'h02);
        reset_cycle(1'b1, 1'b1, MODE_QDR, 8'h01);
        end_sim();
    end
endmodule : adc_demux_reset_sync_test

//--- verif/fpga_word_receiver.sv
// Receiver model that captures the four ports one edge after each forwarded clock rise.
module fpga_word_receiver #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_in,
    input  wire logic         arst_n_in,
    input  wire logic         fwd_clock_in,
    input  wire logic [W-1:0] port_in [4],
    output logic      [W-1:0] word_out [4],
    output logic              seen_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fwd_prev;

    // Captures after the rise, so the ports have settled and stand for the word.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fwd_prev <= 1'b0;
            seen_out <= 1'b0;
            word_out <= '{default: '0};
        end else begin
            fwd_prev <= fwd_clock_in;
            if (fwd_clock_in && !fwd_prev) begin
                word_out <= port_in;
                seen_out <= 1'b1;
            end
        end
    end
endmodule : fpga_word_receiver
